// ---- rtl/sb_access_pkg.sv ----
// constants and types shared by the serial-bus access block
// Contract
// [RULE1] protocol select set: writes go as send-byte, reads as receive-byte
// [RULE2] protocol select set: the byte offset is not sent on the bus
// [RULE3] bit 6 of the control and status register always reads zero
// [RULE4] any write to the slave address register launches an access, sets busy; here a write while busy is set is dropped
// [RULE5] busy stays set until the access ends and read data is in place
// [RULE6] software polls busy after a read and reads data only once clear
// [RULE7] eeprom busy reads 1 during the default auto-load, 0 otherwise
// [RULE8] bit 3 reads 1 when the serial interface was detected; here a write of 1 to bit 3 clears it
// [RULE9] interface not detected: the two bus terminals may take other functions
// [RULE10] test bit clear: clock near 100 kHz; set: faster clock
// [RULE11] missing acknowledge on a requested access sets the request error flag
// [RULE12] request error flag holds until software writes 1 to bit 1
// [RULE13] missing acknowledge during auto-load sets the eeprom error flag
// [RULE14] bad eeprom data format during auto-load sets the eeprom error flag
// [RULE15] eeprom error flag holds until software writes 1 to bit 0
// [RULE16] slave address bit 0 picks direction: 0 write, 1 read
// [RULE17] slave address bits 7 to 1 give the 7-bit device address
// [RULE18] data register holds the byte to send or the byte returned
// [RULE19] index register gives the byte offset sent to the slave
// [RULE20] control and status register is all zero after reset
// [RULE21] indexed access: start, address, offset, data, stop; read uses repeated start
package sb_access_pkg;
  // ----------------------------------------
  // register offsets and fields
  // ----------------------------------------
  localparam logic [7:0] OFF_DATA = 8'hB0;
  localparam logic [7:0] OFF_INDEX = 8'hB1;
  localparam logic [7:0] OFF_SLAVE = 8'hB2;
  localparam logic [7:0] OFF_CTRL = 8'hB3;
  localparam int BIT_PROT = 7;
  localparam int BIT_BUSY = 5;
  localparam int BIT_EEPROM_LOAD_BUSY = 4;
  localparam int BIT_PRESENT = 3;
  localparam int BIT_FAST = 2;
  localparam int BIT_REQERR = 1;
  localparam int BIT_ROMERR = 0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int LINK_CLK_HZ = 6250000;
  localparam int SCL_NORMAL_HZ = 100000;
  localparam logic [3:0] QTR_NORMAL = 4'(LINK_CLK_HZ / (4 * SCL_NORMAL_HZ));
  localparam logic [3:0] QTR_TEST = 4'h1;
  localparam logic [1:0] STRAP_WAIT = 2'h3;
  // ----------------------------------------
  // auto-load defaults
  // ----------------------------------------
  localparam logic [6:0] EE_DEV_ADDR = 7'h50;
  localparam logic [7:0] EE_FORMAT_ID = 8'hA5;
  localparam logic [7:0] EE_LAST_IDX = 8'h07;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {
    OP_START = 3'b000,
    OP_TX = 3'b001,
    OP_RX = 3'b010,
    OP_STOP = 3'b011,
    OP_END = 3'b100
  } op_type;
  typedef enum logic [1:0] {
    LD_WAIT = 2'b00,
    LD_RUN = 2'b01,
    LD_OFF = 2'b10
  } load_type;
endpackage

// ---- rtl/serial_bus_byte_access_control.sv ----
// serial-bus byte access control: register side and bit engine
module serial_bus_byte_access_control (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [7:0] cfg_wdata_i,
  output logic [7:0] cfg_rdata_o,
  input wire logic latch_pulled_low_i,
  output logic multi_terminal_alt_en_o,
  output logic default_we_o,
  output logic [7:0] default_index_o,
  output logic [7:0] default_byte_o,
  input wire logic link_clk_i,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o
);
  // ----------------------------------------
  // register side, ref_clk_i
  // ----------------------------------------
  logic [7:0] data_q, index_q, slave_q, rdata_q;
  logic prot_q, fast_q, busy_q, req_err_q, rom_err_q, present_q;
  logic req_tgl_q, alt_en_q, dflt_we_q;
  logic [7:0] dflt_idx_q, dflt_byte_q;
  logic [7:0] cmd_slave_q, cmd_index_q, cmd_data_q;
  logic cmd_short_q;
  logic rsp_s1_q, rsp_s2_q, rsp_s3_q, lb_s1_q, lb_s2_q, strap_s1_q, strap_s2_q;
  logic [1:0] cap_cnt_q;
  logic cap_done_q;
  // link-domain answer, stable between toggles
  logic rsp_tgl_q, rsp_err_q, rsp_load_q, rsp_rd_q;
  logic [7:0] rsp_data_q, rsp_idx_q;
  logic ld_busy_q;

  wire wr_data = cfg_wr_i && cfg_addr_i == sb_access_pkg::OFF_DATA;
  wire wr_index = cfg_wr_i && cfg_addr_i == sb_access_pkg::OFF_INDEX;
  wire wr_ctrl = cfg_wr_i && cfg_addr_i == sb_access_pkg::OFF_CTRL;
  // a new launch while one is running is dropped to keep the snapshot intact
  wire launch = cfg_wr_i && cfg_addr_i == sb_access_pkg::OFF_SLAVE && !busy_q;
  wire rsp_evt = rsp_s2_q ^ rsp_s3_q;
  wire host_done = rsp_evt && !rsp_load_q;
  wire load_done = rsp_evt && rsp_load_q;
  wire clr_req = wr_ctrl && cfg_wdata_i[sb_access_pkg::BIT_REQERR];
  wire clr_rom = wr_ctrl && cfg_wdata_i[sb_access_pkg::BIT_ROMERR];
  wire clr_pres = wr_ctrl && cfg_wdata_i[sb_access_pkg::BIT_PRESENT];
  wire set_req = host_done && rsp_err_q;
  wire set_rom = load_done && rsp_err_q;
  wire strap_cap = !cap_done_q && cap_cnt_q == sb_access_pkg::STRAP_WAIT;
  wire [7:0] ctrl_val = {prot_q, 1'b0, busy_q, lb_s2_q, present_q, fast_q,
                         req_err_q, rom_err_q}; // [RULE3] [RULE7]
  wire [7:0] rd_mux = cfg_addr_i == sb_access_pkg::OFF_DATA ? data_q :
                      cfg_addr_i == sb_access_pkg::OFF_INDEX ? index_q :
                      cfg_addr_i == sb_access_pkg::OFF_SLAVE ? slave_q :
                      cfg_addr_i == sb_access_pkg::OFF_CTRL ? ctrl_val : 8'h00;

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      data_q <= sb_access_pkg::RST_BYTE;
      index_q <= sb_access_pkg::RST_BYTE;
      slave_q <= sb_access_pkg::RST_BYTE;
      rdata_q <= sb_access_pkg::RST_BYTE;
    end else begin
      if (host_done && rsp_rd_q && !rsp_err_q) begin
        data_q <= rsp_data_q; // [RULE18]
      end else if (wr_data) begin
        data_q <= cfg_wdata_i; // [RULE18]
      end
      if (wr_index) begin
        index_q <= cfg_wdata_i; // [RULE19]
      end
      if (launch) begin
        slave_q <= cfg_wdata_i;
      end
      if (cfg_rd_i) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // control and status bits; set wins over a write-one clear
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prot_q <= 1'b0; // [RULE20]
      fast_q <= 1'b0;
      busy_q <= 1'b0;
      req_err_q <= 1'b0;
      rom_err_q <= 1'b0;
      present_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        prot_q <= cfg_wdata_i[sb_access_pkg::BIT_PROT];
        fast_q <= cfg_wdata_i[sb_access_pkg::BIT_FAST];
      end
      busy_q <= launch | (busy_q & ~host_done); // [RULE4] [RULE5]
      req_err_q <= set_req | (req_err_q & ~clr_req); // [RULE11] [RULE12]
      rom_err_q <= set_rom | (rom_err_q & ~clr_rom); // [RULE13] [RULE15]
      present_q <= (strap_cap & strap_s2_q) | (present_q & ~clr_pres); // [RULE8]
    end
  end

  // launch snapshot and crossings
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      req_tgl_q <= 1'b0;
      cmd_slave_q <= 8'h00;
      cmd_index_q <= 8'h00;
      cmd_data_q <= 8'h00;
      cmd_short_q <= 1'b0;
      rsp_s1_q <= 1'b0;
      rsp_s2_q <= 1'b0;
      rsp_s3_q <= 1'b0;
      lb_s1_q <= 1'b0;
      lb_s2_q <= 1'b0;
      strap_s1_q <= 1'b0;
      strap_s2_q <= 1'b0;
      cap_cnt_q <= 2'h0;
      cap_done_q <= 1'b0;
    end else begin
      if (launch) begin
        req_tgl_q <= ~req_tgl_q; // [RULE4]
        cmd_slave_q <= cfg_wdata_i;
        cmd_index_q <= index_q;
        cmd_data_q <= data_q;
        cmd_short_q <= prot_q;
      end
      rsp_s1_q <= rsp_tgl_q;
      rsp_s2_q <= rsp_s1_q;
      rsp_s3_q <= rsp_s2_q;
      lb_s1_q <= ld_busy_q;
      lb_s2_q <= lb_s1_q;
      strap_s1_q <= latch_pulled_low_i;
      strap_s2_q <= strap_s1_q;
      if (!cap_done_q) begin
        cap_cnt_q <= cap_cnt_q + 2'h1;
      end
      cap_done_q <= cap_done_q | strap_cap;
    end
  end

  // default values handed out as they arrive from the eeprom
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dflt_we_q <= 1'b0;
      dflt_idx_q <= 8'h00;
      dflt_byte_q <= 8'h00;
      alt_en_q <= 1'b1;
    end else begin
      dflt_we_q <= load_done && !rsp_err_q;
      if (load_done) begin
        dflt_idx_q <= rsp_idx_q;
        dflt_byte_q <= rsp_data_q;
      end
      alt_en_q <= ~present_q; // [RULE9]
    end
  end

  assign cfg_rdata_o = rdata_q;
  assign multi_terminal_alt_en_o = alt_en_q;
  assign default_we_o = dflt_we_q;
  assign default_index_o = dflt_idx_q;
  assign default_byte_o = dflt_byte_q;

  // ----------------------------------------
  // link side, link_clk_i
  // ----------------------------------------
  logic [1:0] lrst_q;
  logic req_s1_q, req_s2_q, req_s3_q, fast_s1_q, fast_s2_q, pres_s1_q, pres_s2_q;
  logic sda_s1_q, sda_s2_q, scl_s1_q, scl_s2_q;
  logic run_q, pend_q, is_load_q, err_q, sda_low_q, scl_low_q;
  logic [2:0] step_q;
  logic [1:0] ph_q;
  logic [3:0] bit_q, tick_q;
  logic [7:0] sh_q, ld_idx_q;
  logic [7:0] job_slave_q, job_index_q, job_data_q;
  logic job_short_q;
  sb_access_pkg::load_type ld_st_q;
  sb_access_pkg::op_type op;
  logic [7:0] txb;
  logic [2:0] stop_step;

  wire lrst_b = lrst_q[1];
  wire job_rd = job_slave_q[0]; // [RULE16]
  wire [7:0] addr_w = {job_slave_q[7:1], 1'b0}; // [RULE17]
  wire [7:0] addr_r = {job_slave_q[7:1], 1'b1}; // [RULE17]
  // a slave holding the clock low stretches the high phase
  wire stall = ph_q == 2'h2 && !scl_s2_q;
  wire ph_end = run_q && tick_q == 4'h0 && !stall;
  wire [3:0] qlen = fast_s2_q ? sb_access_pkg::QTR_TEST : sb_access_pkg::QTR_NORMAL; // [RULE10]
  wire is_bit_op = op == sb_access_pkg::OP_TX || op == sb_access_pkg::OP_RX;
  wire op_end = ph_end && ph_q == 2'h3 && (!is_bit_op || bit_q == 4'h8);
  wire nack = ph_end && ph_q == 2'h2 && op == sb_access_pkg::OP_TX && bit_q == 4'h8 && sda_s2_q;
  wire fmt_bad = is_load_q && ld_idx_q == 8'h00 && sh_q != sb_access_pkg::EE_FORMAT_ID; // [RULE14]
  wire txn_end = run_q && op == sb_access_pkg::OP_END;
  wire start_load = !run_q && ld_st_q == sb_access_pkg::LD_RUN;
  wire start_host = !run_q && ld_st_q != sb_access_pkg::LD_RUN && pend_q;
  wire tx_bit = txb[3'(4'h7 - bit_q)];

  // sequence of bus operations per access kind
  always_comb begin
    op = sb_access_pkg::OP_END;
    txb = 8'hFF;
    stop_step = job_short_q ? 3'h3 : (job_rd ? 3'h6 : 3'h4);
    unique case ({job_short_q, job_rd})
      2'b00: begin // [RULE21]
        case (step_q)
          3'h0: op = sb_access_pkg::OP_START;
          3'h1: begin op = sb_access_pkg::OP_TX; txb = addr_w; end
          3'h2: begin op = sb_access_pkg::OP_TX; txb = job_index_q; end
          3'h3: begin op = sb_access_pkg::OP_TX; txb = job_data_q; end
          3'h4: op = sb_access_pkg::OP_STOP;
          default: op = sb_access_pkg::OP_END;
        endcase
      end
      2'b01: begin // [RULE21]
        case (step_q)
          3'h0: op = sb_access_pkg::OP_START;
          3'h1: begin op = sb_access_pkg::OP_TX; txb = addr_w; end
          3'h2: begin op = sb_access_pkg::OP_TX; txb = job_index_q; end
          3'h3: op = sb_access_pkg::OP_START;
          3'h4: begin op = sb_access_pkg::OP_TX; txb = addr_r; end
          3'h5: op = sb_access_pkg::OP_RX;
          3'h6: op = sb_access_pkg::OP_STOP;
          default: op = sb_access_pkg::OP_END;
        endcase
      end
      2'b10: begin // [RULE1] [RULE2]
        case (step_q)
          3'h0: op = sb_access_pkg::OP_START;
          3'h1: begin op = sb_access_pkg::OP_TX; txb = addr_w; end
          3'h2: begin op = sb_access_pkg::OP_TX; txb = job_data_q; end
          3'h3: op = sb_access_pkg::OP_STOP;
          default: op = sb_access_pkg::OP_END;
        endcase
      end
      2'b11: begin // [RULE1] [RULE2]
        case (step_q)
          3'h0: op = sb_access_pkg::OP_START;
          3'h1: begin op = sb_access_pkg::OP_TX; txb = addr_r; end
          3'h2: op = sb_access_pkg::OP_RX;
          3'h3: op = sb_access_pkg::OP_STOP;
          default: op = sb_access_pkg::OP_END;
        endcase
      end
    endcase
  end

  // pin levels per phase; the lone read byte is always answered with nack
  wire sda_low_w = !run_q ? 1'b0 :
    op == sb_access_pkg::OP_START ? ph_q[1] :
    op == sb_access_pkg::OP_STOP ? !ph_q[1] :
    op == sb_access_pkg::OP_TX ? bit_q != 4'h8 && !tx_bit : 1'b0;
  wire scl_low_w = !run_q ? 1'b0 :
    op == sb_access_pkg::OP_START ? (ph_q == 2'h0 && step_q != 3'h0) || ph_q == 2'h3 :
    op == sb_access_pkg::OP_STOP ? ph_q == 2'h0 :
    is_bit_op ? ph_q == 2'h0 || ph_q == 2'h3 : 1'b0;

  always_ff @(posedge link_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lrst_q <= 2'b00;
    end else begin
      lrst_q <= {lrst_q[0], 1'b1};
    end
  end

  always_ff @(posedge link_clk_i or negedge lrst_b) begin
    if (!lrst_b) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_s3_q <= 1'b0;
      fast_s1_q <= 1'b0;
      fast_s2_q <= 1'b0;
      pres_s1_q <= 1'b0;
      pres_s2_q <= 1'b0;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      sda_low_q <= 1'b0;
      scl_low_q <= 1'b0;
    end else begin
      req_s1_q <= req_tgl_q;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
      fast_s1_q <= fast_q;
      fast_s2_q <= fast_s1_q;
      pres_s1_q <= present_q;
      pres_s2_q <= pres_s1_q;
      sda_s1_q <= sda_i;
      sda_s2_q <= sda_s1_q;
      scl_s1_q <= scl_i;
      scl_s2_q <= scl_s1_q;
      sda_low_q <= sda_low_w;
      scl_low_q <= scl_low_w;
    end
  end

  // bit engine and job start
  always_ff @(posedge link_clk_i or negedge lrst_b) begin
    if (!lrst_b) begin
      run_q <= 1'b0;
      pend_q <= 1'b0;
      is_load_q <= 1'b0;
      err_q <= 1'b0;
      step_q <= 3'h0;
      ph_q <= 2'h0;
      bit_q <= 4'h0;
      tick_q <= 4'h0;
      sh_q <= 8'h00;
      job_slave_q <= 8'h00;
      job_index_q <= 8'h00;
      job_data_q <= 8'h00;
      job_short_q <= 1'b0;
    end else begin
      pend_q <= (req_s2_q ^ req_s3_q) | (pend_q & ~start_host);
      if (start_load || start_host) begin
        run_q <= 1'b1;
        is_load_q <= start_load;
        err_q <= 1'b0;
        step_q <= 3'h0;
        ph_q <= 2'h0;
        bit_q <= 4'h0;
        tick_q <= qlen;
        job_slave_q <= start_load ? {sb_access_pkg::EE_DEV_ADDR, 1'b1} : cmd_slave_q;
        job_index_q <= start_load ? ld_idx_q : cmd_index_q;
        job_data_q <= cmd_data_q;
        job_short_q <= start_load ? 1'b0 : cmd_short_q;
      end else if (txn_end) begin
        run_q <= 1'b0;
      end else if (run_q) begin
        tick_q <= ph_end ? qlen : (stall ? tick_q : tick_q - 4'h1);
        if (ph_end) begin
          ph_q <= ph_q + 2'h1;
        end
        if (ph_end && ph_q == 2'h2 && op == sb_access_pkg::OP_RX && bit_q != 4'h8) begin
          sh_q <= {sh_q[6:0], sda_s2_q};
        end
        if (nack) begin
          err_q <= 1'b1; // [RULE11] [RULE13]
        end
        if (op_end) begin
          bit_q <= 4'h0;
          step_q <= (err_q || nack) && step_q < stop_step ? stop_step : step_q + 3'h1;
        end else if (ph_end && ph_q == 2'h3) begin
          bit_q <= bit_q + 4'h1;
        end
      end
    end
  end

  // answers to the register side and the auto-load walk
  always_ff @(posedge link_clk_i or negedge lrst_b) begin
    if (!lrst_b) begin
      rsp_tgl_q <= 1'b0;
      rsp_err_q <= 1'b0;
      rsp_load_q <= 1'b0;
      rsp_rd_q <= 1'b0;
      rsp_data_q <= 8'h00;
      rsp_idx_q <= 8'h00;
      ld_st_q <= sb_access_pkg::LD_WAIT;
      ld_idx_q <= 8'h00;
      ld_busy_q <= 1'b0;
    end else begin
      ld_busy_q <= ld_st_q == sb_access_pkg::LD_RUN; // [RULE7]
      if (ld_st_q == sb_access_pkg::LD_WAIT && pres_s2_q) begin
        ld_st_q <= sb_access_pkg::LD_RUN;
      end
      if (txn_end) begin
        rsp_tgl_q <= ~rsp_tgl_q; // [RULE5]
        rsp_err_q <= err_q | fmt_bad; // [RULE13] [RULE14]
        rsp_load_q <= is_load_q;
        rsp_rd_q <= job_rd;
        rsp_data_q <= sh_q;
        rsp_idx_q <= ld_idx_q;
        if (is_load_q) begin
          if (err_q || fmt_bad || ld_idx_q == sb_access_pkg::EE_LAST_IDX) begin
            ld_st_q <= sb_access_pkg::LD_OFF;
          end else begin
            ld_idx_q <= ld_idx_q + 8'h01;
          end
        end
      end
    end
  end

  // open-drain: only ever pull low
  assign sda_o = 1'b0;
  assign scl_o = 1'b0;
  assign sda_oe_o = sda_low_q;
  assign scl_oe_o = scl_low_q;
endmodule

// ---- bench/sb_access_assertions.sv ----
// concurrent checks on the serial-bus access block ports
module serial_bus_byte_access_control_assertions (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic link_clk_i,
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [7:0] cfg_wdata_i,
  input wire logic [7:0] cfg_rdata_o,
  input wire logic scl_oe_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // helper state
  // ----------------------------------------
  wire logic rd_ctrl = cfg_rd_i && cfg_addr_i == sb_access_pkg::OFF_CTRL;
  wire logic wr_ctrl = cfg_wr_i && cfg_addr_i == sb_access_pkg::OFF_CTRL;
  wire logic wr_slave = cfg_wr_i && cfg_addr_i == sb_access_pkg::OFF_SLAVE;
  logic rd_ctrl_q;
  logic [1:0] err_q;
  logic [1:0] rw_q;
  // flags seen set are remembered until a write-one clears them
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_ctrl_q <= 1'b0;
      err_q <= 2'b00;
      rw_q <= 2'b00;
    end else begin
      rd_ctrl_q <= rd_ctrl;
      if (wr_ctrl) begin
        err_q <= err_q & ~cfg_wdata_i[1:0];
        rw_q <= {cfg_wdata_i[7], cfg_wdata_i[2]};
      end else if (rd_ctrl_q) begin
        err_q <= cfg_rdata_o[1:0];
      end
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  reset_read_zero_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    $rose(rst_b_i) |-> cfg_rdata_o == 8'h00) else $error("read data not zero after reset");
  reserved_zero_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    rd_ctrl |=> !cfg_rdata_o[6]) else $error("reserved bit reads one");
  launch_busy_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    wr_slave ##2 rd_ctrl |=> cfg_rdata_o[5]) else $error("busy not set after launch");
  rw_bits_kept_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    rd_ctrl |=> cfg_rdata_o[7] == rw_q[1] && cfg_rdata_o[2] == rw_q[0])
    else $error("control bits not as written");
  req_err_held_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    rd_ctrl && err_q[1] |=> cfg_rdata_o[1]) else $error("request error lost");
  rom_err_held_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    rd_ctrl && err_q[0] |=> cfg_rdata_o[0]) else $error("eeprom error lost");
  scl_low_min_a: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
    $rose(scl_oe_o) |=> scl_oe_o) else $error("clock low phase too short");
  scl_high_min_a: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
    $fell(scl_oe_o) |=> !scl_oe_o) else $error("clock high phase too short");
endmodule

bind serial_bus_byte_access_control serial_bus_byte_access_control_assertions u_chk (
  .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .link_clk_i(link_clk_i), .cfg_wr_i(cfg_wr_i),
  .cfg_rd_i(cfg_rd_i), .cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i),
  .cfg_rdata_o(cfg_rdata_o), .scl_oe_o(scl_oe_o));

// ---- bench/eeprom_model.sv ----
// two-wire slave model standing in for the serial eeprom
module eeprom_model (
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic bad_fmt_i,
  output logic pull_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [256];
  logic [7:0] sh, ptr, out;
  logic rd;
  int bitc = 9;
  int ph = 9;
  initial begin
    pull_o = 1'b0;
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h3C;
    mem[0] = 8'hA5;
  end
  // start or repeated start
  always @(negedge sda_i) if (scl_i === 1'b1) begin
    ph = 0;
    bitc = 0;
  end
  always @(posedge sda_i) if (scl_i === 1'b1) ph = 9;
  always @(posedge scl_i) if (ph != 9 && bitc < 8) begin
    sh = {sh[6:0], sda_i};
    bitc++;
  end
  // data changes only while the clock is low, so no false start
  always @(negedge scl_i) begin
    if (ph == 9) pull_o = 1'b0;
    else if (bitc == 8) begin
      bitc = 9;
      pull_o = (ph != 3);
      if (ph == 0) begin
        rd = sh[0];
        if (sh[7:1] != 7'h50) begin
          pull_o = 1'b0;
          ph = 9;
        end
      end
      if (ph == 1) ptr = sh;
      if (ph == 2) begin
        mem[ptr] = sh;
        ptr++;
      end
    end else if (bitc == 9) begin
      pull_o = 1'b0;
      bitc = 0;
      if (ph == 3) ph = 9;
      else if (ph == 0) ph = rd ? 3 : 1;
      else ph = 2;
      if (ph == 3) begin
        out = mem[ptr] ^ ((ptr == 8'h00 && bad_fmt_i) ? 8'hFF : 8'h00);
        pull_o = !out[7];
      end
    end else if (ph == 3) pull_o = !out[7 - bitc];
  end
endmodule

// ---- bench/serial_bus_byte_access_control_test.sv ----
// self-checking bench for the serial-bus byte access block
module serial_bus_byte_access_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk_i = 0, link_clk_i = 0, rst_b_i = 0, cfg_wr_i = 0, cfg_rd_i = 0;
  logic latch = 0, bad_fmt = 0, mute = 0, pull;
  logic [7:0] cfg_addr_i = 8'h00, cfg_wdata_i = 8'h00, d;
  logic [7:0] cfg_rdata_o, def_idx, def_byte;
  logic alt_en, def_we, scl_oe, sda_oe;
  int n_errors = 0, n_tests = 0, n_loads = 0;
  wire logic scl_w = ~scl_oe;
  // mute hides the slave's pulls so every byte ends in a nack
  wire logic sda_w = ~(sda_oe | (pull & ~mute));
  always #50 ref_clk_i = ~ref_clk_i;
  initial begin
    #37;
    forever #80 link_clk_i = ~link_clk_i;
  end
  serial_bus_byte_access_control DUT (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
    .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i), .cfg_addr_i(cfg_addr_i),
    .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o), .latch_pulled_low_i(latch),
    .multi_terminal_alt_en_o(alt_en), .default_we_o(def_we), .default_index_o(def_idx),
    .default_byte_o(def_byte), .link_clk_i(link_clk_i), .scl_i(scl_w), .scl_o(),
    .scl_oe_o(scl_oe), .sda_i(sda_w), .sda_o(), .sda_oe_o(sda_oe));
  eeprom_model u_ee (.scl_i(scl_w), .sda_i(sda_w), .bad_fmt_i(bad_fmt), .pull_o(pull));
  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk_i);
    cfg_wr_i <= 1'b1;
    cfg_addr_i <= a;
    cfg_wdata_i <= v;
    @(posedge ref_clk_i);
    cfg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge ref_clk_i);
    cfg_rd_i <= 1'b1;
    cfg_addr_i <= a;
    @(posedge ref_clk_i);
    cfg_rd_i <= 1'b0;
    @(negedge ref_clk_i);
    v = cfg_rdata_o;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input string n);
    rd(a, d);
    chk(n, e, d);
  endtask
  // polling is bounded so a stuck flag ends as a mismatch
  task automatic wait_bit(input int b, input logic v);
    int k;
    k = 0;
    d = ~{8{v}};
    while (d[b] !== v && k < 4000) begin
      rd(sb_access_pkg::OFF_CTRL, d);
      k++;
    end
    chk("flag wait", v, d[b]);
  endtask
  task automatic measure(input int e);
    realtime t0;
    @(posedge scl_w);
    @(posedge scl_w);
    t0 = $realtime;
    @(posedge scl_w);
    chk("clock period", e, int'($realtime - t0));
  endtask
  task automatic do_reset(input logic strap, input logic bad);
    @(posedge ref_clk_i);
    rst_b_i <= 1'b0;
    latch <= strap;
    bad_fmt <= bad;
    repeat (3) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    n_loads = 0;
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge ref_clk_i) if (def_we === 1'b1) begin
    chk("load index", n_loads, def_idx);
    chk("load byte", n_loads == 0 ? 8'hA5 : 8'(n_loads) ^ 8'h3C, def_byte);
    n_loads++;
  end
  initial begin
    repeat (60000) @(posedge ref_clk_i);
    n_errors++;
    final_report;
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    do_reset(1'b1, 1'b0);
    rdchk(sb_access_pkg::OFF_CTRL, 8'h00, "ctrl reset");
    wr(sb_access_pkg::OFF_CTRL, 8'h04);
    wait_bit(4, 1'b1);
    wait_bit(4, 1'b0);
    chk("loads", 8, n_loads);
    rdchk(sb_access_pkg::OFF_CTRL, 8'h0C, "ctrl present");
    chk("alt enable", 0, alt_en);
    $display("test auto-load done");
    wr(sb_access_pkg::OFF_CTRL, 8'h00);
    wr(sb_access_pkg::OFF_DATA, 8'h77);
    wr(sb_access_pkg::OFF_INDEX, 8'h12);
    wr(sb_access_pkg::OFF_SLAVE, 8'hA0);
    // a quarter spans its reload cycle too: 4 x 16 link cycles
    measure(10240);
    wait_bit(5, 1'b0);
    wr(sb_access_pkg::OFF_CTRL, 8'h04);
    wr(sb_access_pkg::OFF_SLAVE, 8'hA1);
    rd(sb_access_pkg::OFF_CTRL, d);
    chk("busy", 1, d[5]);
    // pin sync latency stretches the short high phase by one cycle
    measure(1440);
    wait_bit(5, 1'b0);
    rdchk(sb_access_pkg::OFF_DATA, 8'h77, "read back");
    wr(sb_access_pkg::OFF_INDEX, 8'h05);
    wr(sb_access_pkg::OFF_SLAVE, 8'hA1);
    wait_bit(5, 1'b0);
    rdchk(sb_access_pkg::OFF_DATA, 8'h39, "indexed read");
    $display("test requested access done");
    wr(sb_access_pkg::OFF_CTRL, 8'h84);
    wr(sb_access_pkg::OFF_DATA, 8'h12);
    wr(sb_access_pkg::OFF_SLAVE, 8'hA0);
    wait_bit(5, 1'b0);
    wr(sb_access_pkg::OFF_SLAVE, 8'hA1);
    wait_bit(5, 1'b0);
    rdchk(sb_access_pkg::OFF_DATA, 8'h77, "receive byte");
    rdchk(sb_access_pkg::OFF_CTRL, 8'h8C, "protocol select");
    $display("test short protocol done");
    wr(sb_access_pkg::OFF_CTRL, 8'h04);
    wr(sb_access_pkg::OFF_SLAVE, 8'h46);
    wait_bit(5, 1'b0);
    rdchk(sb_access_pkg::OFF_CTRL, 8'h0E, "request error");
    rdchk(sb_access_pkg::OFF_CTRL, 8'h0E, "request error held");
    rdchk(sb_access_pkg::OFF_DATA, 8'h77, "data kept");
    wr(sb_access_pkg::OFF_CTRL, 8'h46);
    rdchk(sb_access_pkg::OFF_CTRL, 8'h0C, "error cleared");
    $display("test request error done");
    do_reset(1'b1, 1'b1);
    wr(sb_access_pkg::OFF_CTRL, 8'h04);
    wait_bit(4, 1'b1);
    wait_bit(4, 1'b0);
    rdchk(sb_access_pkg::OFF_CTRL, 8'h0D, "eeprom error");
    chk("bad loads", 0, n_loads);
    wr(sb_access_pkg::OFF_CTRL, 8'h05);
    rdchk(sb_access_pkg::OFF_CTRL, 8'h0C, "eeprom error cleared");
    mute <= 1'b1;
    do_reset(1'b1, 1'b0);
    wr(sb_access_pkg::OFF_CTRL, 8'h04);
    wait_bit(4, 1'b1);
    wait_bit(4, 1'b0);
    rdchk(sb_access_pkg::OFF_CTRL, 8'h0D, "eeprom nack");
    chk("nack loads", 0, n_loads);
    mute <= 1'b0;
    do_reset(1'b0, 1'b0);
    repeat (20) @(posedge ref_clk_i);
    rdchk(sb_access_pkg::OFF_CTRL, 8'h00, "absent");
    chk("alt enable absent", 1, alt_en);
    $display("test eeprom error and absence done");
    final_report;
  end
endmodule
